/* File: common/tape_ctl_pkg.sv */
package tape_ctl_pkg;

	// ============================================================
	// Code values
	localparam int          CODE_W           = 8;
	localparam logic [7:0] CODE_HALT        = 8'h0B;
	localparam logic [7:0] CODE_ALL7        = 8'h7F;
	localparam logic [7:0] BITS_AUX         = 8'h0C;
	localparam logic [7:0] BIT_HIGH         = 8'h80;
	localparam logic [7:0] CODE_SKIP_RESUME = 8'h79;
	localparam logic [7:0] CODE_PUNCH_ON    = 8'h7C;
	localparam logic [7:0] CODE_PUNCH_OFF   = 8'h76;

	// ============================================================
	// Register map and fields
	localparam int          REG_ADDR_W  = 4;
	localparam int          DATA_W      = 32;
	localparam logic [3:0] ADDR_CMD    = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_LAST   = 4'h8;
	localparam int          CMD_ON_BIT  = 0;
	localparam int          CMD_OFF_BIT = 1;
	localparam int          ST_STATE_LSB = 0;
	localparam int          ST_PON_BIT  = 2;
	localparam int          ST_PERR_BIT = 3;
	localparam int          ST_OFF_BIT  = 4;
	localparam int          ST_ALL_BIT  = 5;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ============================================================
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int FEED_PERIOD_MS = 60;
	localparam int FEED_CYCLES    = FEED_PERIOD_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_REPRO, ST_SKIP} reader_state_t;

endpackage : tape_ctl_pkg

/* File: common/code_check_if.sv */
// Carries one code to the translator and its decoded meaning back
interface code_check_if;
	logic [7:0] code;
	logic       isHalt;
	logic       isSkipResume;
	logic       isPunchOn;
	logic       isPunchOff;
	modport decoder(input code, output isHalt, isSkipResume, isPunchOn, isPunchOff);
	modport user(output code, input isHalt, isSkipResume, isPunchOn, isPunchOff);
endinterface : code_check_if

/* File: design/code_translator.sv */
module code_translator
	import tape_ctl_pkg::*;
(
	code_check_if.decoder chk
);

	// ============================================================
	// Function decode; anything not matched acts as a plain keylever
	// keylever or function
	assign chk.isHalt       = (chk.code == CODE_HALT);
	assign chk.isSkipResume = (chk.code == CODE_SKIP_RESUME);
	assign chk.isPunchOn    = (chk.code == CODE_PUNCH_ON);
	assign chk.isPunchOff   = (chk.code == CODE_PUNCH_OFF);

endmodule : code_translator

/* File: design/tape_reader_punch_control.sv */
// The AXI4-Lite register port and the address map were decided locally.
module tape_reader_punch_control
	import tape_ctl_pkg::*;
#(
	parameter int FEED_CYCLES_P = FEED_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire logic [REG_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [REG_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [DATA_W-1:0]          rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  beginKey,
	input  wire logic                  haltKey,
	input  wire logic                  reproKey,
	input  wire logic                  skipKey,
	input  wire logic                  auxKey,
	input  wire logic                  haltCodeKey,
	input  wire logic                  feedKey,
	input  wire logic                  high_bit_word_end_key,
	input  wire logic                  switchAll,
	input  wire logic                  switchOff,
	input  wire logic                  keyStrobe,
	input  wire logic [7:0]            keyCode,
	input  wire logic                  readStrobe,
	input  wire logic [7:0]            readCode,
	output logic                       readerRun,
	output logic                       punchStrobe,
	output logic [7:0]                 punchCode,
	output logic                       punchLamp,
	output logic                       cpuStrobe,
	output logic [7:0]                 cpuCode,
	output logic                       cpuDirect,
	output logic                       wordEnd
);

	// ============================================================
	// Pin synchronisers
	localparam int P_BEGIN = 0;
	localparam int P_HALT  = 1;
	localparam int P_REPRO = 2;
	localparam int P_SKIP  = 3;
	localparam int P_AUX   = 4;
	localparam int P_HCODE = 5;
	localparam int P_FEED  = 6;
	localparam int P_HIGH  = 7;
	localparam int P_ALL   = 8;
	localparam int P_OFF   = 9;
	localparam int P_KSTB  = 10;
	localparam int P_RSTB  = 11;
	localparam int P_KCODE = 12;
	localparam int P_RCODE = 20;
	localparam int NPIN    = 28;

	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] syncB;
	logic [NPIN-1:0] syncPrev;

	assign pinRaw = {readCode, keyCode, readStrobe, keyStrobe, switchOff, switchAll,
		high_bit_word_end_key, feedKey, haltCodeKey, auxKey, skipKey, reproKey,
		haltKey, beginKey};

	// Codes pass the same two stages as their strobes, so they stay aligned
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic stageA;
			logic stageB;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stageA <= 1'b0;
					stageB <= 1'b0;
				end else if (ce) begin
					stageA <= pinRaw[gi];
					stageB <= stageA;
				end
			end
			assign syncB[gi] = stageB;
		end
	endgenerate

	// Previous synchronised levels for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncPrev <= '0;
		end else if (ce) begin
			syncPrev <= syncB;
		end
	end

	// ============================================================
	// Key events
	logic       beginHeld;
	logic       beginRel;
	logic       haltRel;
	logic       reproPress;
	logic       skipPress;
	logic       haltCodeRel;
	logic       highHeld;
	logic       highRel;
	logic       keyEv;
	logic       rdEv;
	logic       swAll;
	logic       swOff;
	logic [7:0] keyCodeS;
	logic [7:0] rdCodeS;

	assign beginHeld   = syncB[P_BEGIN];
	assign beginRel    = syncPrev[P_BEGIN] & ~syncB[P_BEGIN];
	assign haltRel     = syncPrev[P_HALT] & ~syncB[P_HALT];
	assign reproPress  = syncB[P_REPRO] & ~syncPrev[P_REPRO];
	assign skipPress   = syncB[P_SKIP] & ~syncPrev[P_SKIP];
	assign haltCodeRel = syncPrev[P_HCODE] & ~syncB[P_HCODE];
	assign highHeld    = syncB[P_HIGH];
	assign highRel     = syncPrev[P_HIGH] & ~syncB[P_HIGH];
	assign keyEv       = syncB[P_KSTB] & ~syncPrev[P_KSTB];
	assign rdEv        = syncB[P_RSTB] & ~syncPrev[P_RSTB];
	assign swAll       = syncB[P_ALL];
	assign swOff       = syncB[P_OFF];
	assign keyCodeS    = syncB[P_KCODE +: 8];
	assign rdCodeS     = syncB[P_RCODE +: 8];

	// ============================================================
	// Tape feed repeat timer
	logic [31:0] feedCnt;
	logic        feedFire;

	assign feedFire = syncB[P_FEED] && (feedCnt == 32'h0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			feedCnt <= 32'h0;
		end else if (ce) begin
			if (!syncB[P_FEED])
				feedCnt <= 32'h0;
			else if (feedFire)
				feedCnt <= 32'(FEED_CYCLES_P - 1);
			else
				feedCnt <= feedCnt - 32'h1;
		end
	end

	// ============================================================
	// Reader control and translation
	reader_state_t state;
	reader_state_t next_state;
	logic          rdUse;
	code_check_if  chk();

	code_translator u_translator (
		.chk(chk.decoder)
	);

	// A reader code arriving with a feed, halt-code or keylever event is dropped; the panel wins
	assign rdUse    = rdEv && (state != ST_IDLE) && !(feedFire || haltCodeRel || keyEv);
	assign chk.code = keyEv ? keyCodeS : rdCodeS;

	// Next reader state; halt key has top priority
	always_comb begin
		next_state = state;
		if (haltRel)
			next_state = ST_IDLE;
		else if (reproPress)
			next_state = ST_REPRO;
		else if (skipPress)
			next_state = ST_SKIP;
		else if (beginRel && state == ST_IDLE)
			next_state = ST_READ;
		else if (rdUse) begin
			case (state)
				ST_READ, ST_REPRO: if (chk.isHalt) next_state = ST_IDLE;
				ST_SKIP: if (chk.isSkipResume) next_state = ST_READ;
				default: next_state = state;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readerRun <= 1'b0;
		end else if (ce) begin
			readerRun <= (next_state != ST_IDLE) && !beginHeld;
		end
	end

	// ============================================================
	// Code event selection
	logic       evValid;
	logic [7:0] evCode;
	logic       evCpu;
	logic       evDirect;
	logic       evCtl;

	always_comb begin
		evValid  = 1'b0;
		evCode   = 8'h00;
		evCpu    = 1'b0;
		evDirect = 1'b0;
		evCtl    = 1'b0;
		if (feedFire) begin
			evValid = 1'b1;
			evCode  = CODE_ALL7;
		end else if (haltCodeRel) begin
			evValid = 1'b1;
			evCode  = CODE_HALT;
		end else if (keyEv) begin
			evValid = 1'b1;
			evCode  = keyCodeS | (syncB[P_AUX] ? BITS_AUX : 8'h00) | (highHeld ? BIT_HIGH : 8'h00);
			evCpu   = 1'b1;
			evCtl   = chk.isPunchOn || chk.isPunchOff;
		end else if (rdUse && state != ST_SKIP) begin
			evValid  = 1'b1;
			evCode   = rdCodeS;
			evCpu    = 1'b1;
			evDirect = (state == ST_REPRO);
			evCtl    = (state == ST_READ) && (chk.isPunchOn || chk.isPunchOff);
		end
	end

	// ============================================================
	// Punch enable
	logic selOn;
	logic punchOn;
	logic cmdOn;
	logic cmdOff;

	assign punchOn = swAll ? 1'b1 : (swOff ? 1'b0 : selOn);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selOn <= 1'b0;
		end else if (ce) begin
			if (cmdOn || (evCtl && chk.isPunchOn))
				selOn <= 1'b1;
			else if (cmdOff || (evCtl && chk.isPunchOff))
				selOn <= 1'b0;
		end
	end

	// Punch and processor outputs; control keylevers punch only under all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			punchStrobe <= 1'b0;
			punchCode   <= 8'h00;
			cpuStrobe   <= 1'b0;
			cpuCode     <= 8'h00;
			cpuDirect   <= 1'b0;
			punchLamp   <= 1'b0;
		end else if (ce) begin
			punchStrobe <= evValid && punchOn && !(evCtl && !swAll);
			punchCode   <= evCode;
			cpuStrobe   <= evValid && evCpu;
			cpuCode     <= evCode;
			cpuDirect   <= evDirect;
			punchLamp   <= punchOn;
		end
	end

	// ============================================================
	// Word end from the high-bit key used alone
	logic highUsed;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			highUsed <= 1'b0;
			wordEnd  <= 1'b0;
		end else if (ce) begin
			wordEnd <= highRel && !highUsed && !keyEv;
			if (highRel)
				highUsed <= 1'b0;
			else if (highHeld && keyEv)
				highUsed <= 1'b1;
		end
	end

	// ============================================================
	// Parity check and last punched code
	logic       parityErr;
	logic       clrPerr;
	logic [7:0] lastCode;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parityErr <= 1'b0;
			lastCode  <= 8'h00;
		end else if (ce) begin
			if (punchStrobe && !(^punchCode))
				parityErr <= 1'b1;
			else if (clrPerr)
				parityErr <= 1'b0;
			if (punchStrobe)
				lastCode <= punchCode;
		end
	end

	// ============================================================
	// AXI4-Lite write channel
	logic [REG_ADDR_W-1:0] awAddrQ;
	logic [DATA_W-1:0]     wDataQ;
	logic                  wLaneQ;
	logic                  doWrite;

	// Both halves held and no response pending
	assign doWrite = !awready && !wready && !bvalid;
	assign cmdOn   = doWrite && awAddrQ == ADDR_CMD && wLaneQ && wDataQ[CMD_ON_BIT];
	assign cmdOff  = doWrite && awAddrQ == ADDR_CMD && wLaneQ && wDataQ[CMD_OFF_BIT];
	assign clrPerr = doWrite && awAddrQ == ADDR_STATUS && wLaneQ && wDataQ[ST_PERR_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awAddrQ <= '0;
			wDataQ  <= '0;
			wLaneQ  <= 1'b0;
		end else if (ce) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awAddrQ <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wDataQ <= wdata;
				wLaneQ <= wstrb[0];
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= (awAddrQ == ADDR_CMD || awAddrQ == ADDR_STATUS || awAddrQ == ADDR_LAST)
					? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// ============================================================
	// AXI4-Lite read channel
	logic [DATA_W-1:0] next_rdata;
	logic              next_rerr;

	always_comb begin
		next_rdata = '0;
		next_rerr  = 1'b0;
		case (araddr)
			ADDR_CMD: next_rdata[CMD_ON_BIT] = selOn;
			ADDR_STATUS: begin
				next_rdata[ST_STATE_LSB +: 2] = state;
				next_rdata[ST_PON_BIT]        = punchOn;
				next_rdata[ST_PERR_BIT]       = parityErr;
				next_rdata[ST_OFF_BIT]        = swOff;
				next_rdata[ST_ALL_BIT]        = swAll;
			end
			ADDR_LAST: next_rdata[7:0] = lastCode;
			default: next_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= next_rdata;
				rresp   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_run_active: assert property (readerRun |-> state != ST_IDLE)
		else $error("reader runs while idle");

	a_halt_stops: assert property (ce && haltRel |=> state == ST_IDLE && !readerRun)
		else $error("halt key did not stop reading");

	a_begin_pause: assert property (ce && beginHeld |=> !readerRun)
		else $error("reader ran while begin key held");

	a_repro_start: assert property (ce && reproPress && !haltRel |=> state == ST_REPRO)
		else $error("reproduce key ignored");

	// halt code ends reproduce after punching
	a_repro_halt: assert property (ce && state == ST_REPRO && rdUse && chk.isHalt
		&& punchOn && !haltRel && !reproPress && !skipPress
		|=> state == ST_IDLE && punchStrobe && punchCode == CODE_HALT && cpuDirect)
		else $error("halt code not reproduced before stop");

	a_skip_silent: assert property (ce && state == ST_SKIP && rdUse |=> !punchStrobe && !cpuStrobe)
		else $error("skip produced an output");

	a_aux_bits: assert property (ce && keyEv && syncB[P_AUX] && !feedFire
		&& !haltCodeRel |=> cpuStrobe && cpuCode[3:2] == 2'h3)
		else $error("aux bits missing");

	a_halt_code: assert property (ce && haltCodeRel && !feedFire && punchOn
		|=> punchStrobe && punchCode == CODE_HALT && !cpuStrobe)
		else $error("halt code not punched");

	a_feed_code: assert property (ce && feedFire && punchOn |=> punchStrobe && punchCode == CODE_ALL7)
		else $error("feed pattern wrong");

	a_high_bit: assert property (ce && keyEv && highHeld && !feedFire
		&& !haltCodeRel |=> cpuStrobe && cpuCode[7])
		else $error("high bit missing");

	a_word_end: assert property (ce && highRel && !highUsed && !keyEv && !feedFire
		&& !haltCodeRel && !rdUse |=> wordEnd && !punchStrobe && !cpuStrobe)
		else $error("word end missing or punched");

	a_off_inhibit: assert property (ce && swOff && !swAll |=> !punchStrobe)
		else $error("punch fired while switched off");

	a_all_punch: assert property (ce && swAll && keyEv |=> punchStrobe)
		else $error("keylever not punched under all");

	a_parity_flag: assert property (ce && punchStrobe && !(^punchCode) |=> parityErr)
		else $error("even parity code not flagged");

	a_direct_src: assert property (ce && cpuStrobe && cpuDirect |-> $past(state) == ST_REPRO)
		else $error("direct code outside reproduce");

endmodule : tape_reader_punch_control

/* File: verif/cpu_model.sv */
// Processor side: latches every code impulse and end-of-word mark
module cpu_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       cpuStrobe,
	input  wire logic [7:0] cpuCode,
	input  wire logic       cpuDirect,
	input  wire logic       wordEnd,
	output int              strobeCount,
	output logic [7:0]      lastCode,
	output logic            lastDirect,
	output int              wordEndCount
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Impulse capture
	// code and path
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobeCount <= 0;
			lastCode    <= 8'h00;
			lastDirect  <= 1'b0;
		end else if (cpuStrobe) begin
			strobeCount <= strobeCount + 1;
			lastCode    <= cpuCode;
			lastDirect  <= cpuDirect;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wordEndCount <= 0;
		end else if (wordEnd) begin
			wordEndCount <= wordEndCount + 1;
		end
	end
endmodule : cpu_model

/* File: verif/tb_top.sv */
module tb_top
	import tape_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 0, rst_n = 0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0;
	logic [7:0] keys = 8'h00, keyCode = 8'h00, readCode = 8'h00;
	logic keyStrobe = 0, readStrobe = 0, switchAll = 1, switchOff = 0;
	logic awready, wready, bvalid, arready, rvalid, readerRun, punchStrobe, punchLamp;
	logic cpuStrobe, cpuDirect, wordEnd, lastDirect;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, v;
	logic [7:0] punchCode, cpuCode, lastCpu, lastPunch;
	int bad_count = 0, n_compared = 0, cyc = 0, punchCount, cpuCount, weCount, p0, c0;

	always #5 clk = ~clk;

	// Panel keys: 0 begin,1 halt,2 repro,3 skip,4 aux,5 halt code,6 feed,7 high
	tape_reader_punch_control #(.FEED_CYCLES_P(8)) dut (.clk(clk), .rst_n(rst_n),
		.ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.beginKey(keys[0]), .haltKey(keys[1]), .reproKey(keys[2]), .skipKey(keys[3]),
		.auxKey(keys[4]), .haltCodeKey(keys[5]), .feedKey(keys[6]),
		.high_bit_word_end_key(keys[7]), .switchAll(switchAll), .switchOff(switchOff),
		.keyStrobe(keyStrobe), .keyCode(keyCode), .readStrobe(readStrobe),
		.readCode(readCode), .readerRun(readerRun), .punchStrobe(punchStrobe),
		.punchCode(punchCode), .punchLamp(punchLamp), .cpuStrobe(cpuStrobe),
		.cpuCode(cpuCode), .cpuDirect(cpuDirect), .wordEnd(wordEnd));

	cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpuStrobe(cpuStrobe), .cpuCode(cpuCode),
		.cpuDirect(cpuDirect), .wordEnd(wordEnd), .strobeCount(cpuCount),
		.lastCode(lastCpu), .lastDirect(lastDirect), .wordEndCount(weCount));

	// Punch monitor; strobe is a single cycle so it is counted at every edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			punchCount <= 0;
			lastPunch  <= 8'h00;
		end else if (punchStrobe) begin
			punchCount <= punchCount + 1;
			lastPunch  <= punchCode;
		end
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	// ============================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready) begin
				w = 0;
				wvalid <= 0;
			end
		end
		bready <= 1;
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 0;
		tick(1);
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1;
		do @(posedge clk); while (!arready);
		arvalid <= 0;
		rready <= 1;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		rr = rresp;
		rready <= 0;
		tick(1);
	endtask : axr

	task automatic press(input int k);
		keys[k] <= 1;
		tick(6);
		keys[k] <= 0;
		tick(6);
	endtask : press

	// Code set two cycles ahead of the strobe and held well past it
	task automatic lever(input logic [7:0] c, input logic rdr);
		p0 = punchCount;
		c0 = cpuCount;
		if (rdr) readCode <= c; else keyCode <= c;
		tick(2);
		if (rdr) readStrobe <= 1; else keyStrobe <= 1;
		tick(6);
		if (rdr) readStrobe <= 0; else keyStrobe <= 0;
		tick(4);
	endtask : lever

	task automatic state_is(input logic [1:0] s);
		axr(ADDR_STATUS, v);
		chk("state", v[ST_STATE_LSB+:2], s);
	endtask : state_is

	// ============================================================
	// Scenarios
	task automatic t_levers();
		lever(8'h01, 0);
		chk("punch", {24'(punchCount - p0), lastPunch}, {24'd1, 8'h01});
		chk("cpu", {24'(cpuCount - c0), lastCpu}, {24'd1, 8'h01});
		keys[4] <= 1;
		tick(4);
		lever(8'h01, 0);
		chk("aux", lastPunch, 8'h01 | BITS_AUX);
		keys[4] <= 0;
		keys[7] <= 1;
		tick(4);
		lever(8'h03, 0);
		chk("high", lastPunch, 8'h83);
		chk("no end", weCount, 0);
		keys[7] <= 0;
		tick(6);
		press(4);
		chk("aux alone", punchCount - p0, 1);
		press(7);
		chk("word end", weCount, 1);
		chk("end no punch", punchCount - p0, 1);
	endtask : t_levers

	task automatic t_parity();
		lever(8'h03, 0);
		axr(ADDR_STATUS, v);
		chk("perr", v[ST_PERR_BIT], 1);
		chk("status", v, 32'(1 << ST_PON_BIT | 1 << ST_PERR_BIT | 1 << ST_ALL_BIT));
		axw(ADDR_STATUS, 32'h8, v[1:0]);
		axr(ADDR_STATUS, v);
		chk("perr clr", v[ST_PERR_BIT], 0);
		axr(ADDR_LAST, v);
		chk("last", v, 32'h03);
	endtask : t_parity

	task automatic t_off_select();
		switchAll <= 0;
		switchOff <= 1;
		tick(4);
		lever(8'h01, 0);
		chk("off", punchCount - p0, 0);
		chk("off cpu", cpuCount - c0, 1);
		switchOff <= 0;
		tick(4);
		axw(ADDR_CMD, 32'h1, v[1:0]);
		chk("on resp", v[1:0], RESP_OKAY);
		chk("lamp", punchLamp, 1);
		axr(ADDR_CMD, v);
		chk("sel flag", v, 32'h1);
		lever(8'h01, 0);
		chk("sel", punchCount - p0, 1);
		lever(CODE_PUNCH_OFF, 0);
		chk("lever off", {punchLamp, 7'(punchCount - p0)}, 8'h00);
		lever(CODE_PUNCH_ON, 0);
		chk("lever on", {punchLamp, 7'(punchCount - p0)}, 8'h80);
		axw(ADDR_CMD, 32'h1, v[1:0]);
		axw(ADDR_CMD, 32'h2, v[1:0]);
		chk("cmd off", punchLamp, 0);
		axw(4'hC, 32'h1, v[1:0]);
		chk("unmapped", v[1:0], RESP_SLVERR);
		axr(4'hC, v);
		chk("rd unmapped", rr, RESP_SLVERR);
		switchAll <= 1;
		tick(4);
	endtask : t_off_select

	task automatic t_punch_keys();
		p0 = punchCount;
		c0 = cpuCount;
		press(5);
		chk("stop code", {24'(punchCount - p0), lastPunch}, {24'd1, CODE_HALT});
		p0 = punchCount;
		keys[6] <= 1;
		tick(30);
		keys[6] <= 0;
		tick(6);
		chk("feed n", (punchCount - p0) >= 3, 1);
		chk("feed code", lastPunch, CODE_ALL7);
		chk("no cpu", cpuCount - c0, 0);
	endtask : t_punch_keys

	task automatic t_reader();
		lever(8'h01, 1);
		chk("idle rd", punchCount - p0, 0);
		press(0);
		chk("run", readerRun, 1);
		state_is(2'd1);
		keys[0] <= 1;
		tick(6);
		chk("pause", readerRun, 0);
		keys[0] <= 0;
		tick(6);
		chk("resume", readerRun, 1);
		lever(8'h01, 1);
		chk("rd", {16'(punchCount - p0), lastCpu, 7'h00, lastDirect}, 32'h0001_0100);
		lever(CODE_HALT, 1);
		chk("rd stop", readerRun, 0);
		state_is(2'd0);
		press(2);
		state_is(2'd2);
		lever(8'h01, 1);
		chk("repro", {lastPunch, lastCpu, 7'h00, lastDirect}, 24'h01_01_01);
		lever(CODE_HALT, 1);
		chk("repro end", lastPunch, CODE_HALT);
		state_is(2'd0);
		press(2);
		press(1);
		state_is(2'd0);
		press(3);
		state_is(2'd3);
		lever(8'h01, 1);
		chk("skip", {16'(punchCount - p0), 16'(cpuCount - c0)}, 32'h0);
		lever(CODE_SKIP_RESUME, 1);
		state_is(2'd1);
		press(3);
		press(1);
		state_is(2'd0);
	endtask : t_reader

	initial begin
		tick(10);
		chk("reset out", {awready, wready, arready, punchStrobe, readerRun, punchLamp}, 6'h38);
		rst_n <= 1;
		tick(4);
		t_levers();
		t_parity();
		t_off_select();
		t_punch_keys();
		t_reader();
		wrap_up();
	end
endmodule : tb_top
